/* File: hdl/octal_switch_core.sv */
// octal low-side switch command logic: serial word capture, settings,
// pin combination, per-output short protection, open-load re-detection
// assumes fault inputs are hysteretic comparator levels from pins
`default_nettype none
`include "osw_consts.svh"
module octal_switch_core
    import octal_switch_pkg::*;
#(
    parameter int REFRESH_CYC  = `OSW_REFRESH_MS * 1000 * `OSW_CLK_MHZ,
    parameter int SHORT_CYC    = `OSW_SHORT_US * `OSW_CLK_MHZ,
    parameter int REDETECT_CYC = `OSW_REDETECT_US * `OSW_CLK_MHZ
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       linkClk,
    input  wire logic       linkCsN,
    input  wire logic       linkMosi,
    input  wire logic [3:0] directPin,
    input  wire logic       supplyOverVolt,
    input  wire logic [7:0] thermalLimit,
    input  wire logic [7:0] shortVolt,
    input  wire logic [7:0] shortCur,
    input  wire logic [7:0] openLoadRaw,
    output var  logic [7:0] switchOutputs_r,
    output var  logic [7:0] pulldownEn_r,
    output var  logic [7:0] faultStatus_r,
    output var  logic [7:0] openLoadFlag_r,
    output var  logic [7:0] curLimitActive_r
);
    import octal_switch_pkg::*;

    localparam int CLIMIT_CYC = `OSW_CLIMIT_US * `OSW_CLK_MHZ;
    // one counter serves the short, current-limit and refresh windows, so it is sized for the longest
    localparam int LONG_A  = (REFRESH_CYC > CLIMIT_CYC) ? REFRESH_CYC
                                                        : CLIMIT_CYC;
    localparam int LONGEST = (LONG_A > SHORT_CYC) ? LONG_A : SHORT_CYC;
    localparam int CW  = $clog2(LONGEST + 1);
    localparam int BW  = $clog2(REDETECT_CYC + 1);
    localparam logic [CW-1:0] REFRESH_LAST = CW'(REFRESH_CYC - 1);
    localparam logic [CW-1:0] SHORT_LAST   = CW'(SHORT_CYC - 1);
    localparam logic [CW-1:0] CLIMIT_LAST  = CW'(CLIMIT_CYC - 1);
    localparam logic [BW-1:0] REDET_LOAD   = BW'(REDETECT_CYC);
    localparam int SW = 2 + 4 + 8 * 4;

    ////////////////////////////////////////////////////////////////////
    // link domain: shift in on the link clock while selected

    logic [`OSW_WORD_BITS-1:0] linkShift_r;
    logic [`OSW_WORD_BITS-1:0] linkShift_nxt;

    always_comb begin
        linkShift_nxt = linkShift_r;
        if (!linkCsN)
            linkShift_nxt = {linkShift_r[`OSW_WORD_BITS-2:0], linkMosi};
    end

    // no reset here: the link clock only runs inside frames
    always_ff @(posedge linkClk) begin
        linkShift_r <= linkShift_nxt;
    end

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers

    // select crosses as active high so its reset value is the idle level
    logic       selSync;
    logic       ovSync;
    logic [3:0] pinSync;
    logic [7:0] thermSync;
    logic [7:0] svSync;
    logic [7:0] scSync;
    logic [7:0] olSync;

    sync_two_flop #(.W(SW)) u_sync (
        .clk (core_clk),
        .rst (rst),
        .d   ({~linkCsN, supplyOverVolt, directPin, thermalLimit,
               shortVolt, shortCur, openLoadRaw}),
        .q   ({selSync, ovSync, pinSync, thermSync,
               svSync, scSync, olSync})
    );

    ////////////////////////////////////////////////////////////////////
    // frame commit: shift register is quiet once select has risen

    logic                      csPrev_r;
    logic                      csPrev_nxt;
    logic                      cmdStb_r;
    logic                      cmdStb_nxt;
    logic [`OSW_WORD_BITS-1:0] word_r;
    logic [`OSW_WORD_BITS-1:0] word_nxt;
    logic                      csRise;

    always_comb begin
        csRise     = ~selSync & csPrev_r;
        csPrev_nxt = selSync;
        cmdStb_nxt = csRise;
        word_nxt   = csRise ? linkShift_r : word_r;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            csPrev_r <= 1'b0;
            cmdStb_r <= 1'b0;
            word_r   <= '0;
        end else begin
            csPrev_r <= csPrev_nxt;
            cmdStb_r <= cmdStb_nxt;
            word_r   <= word_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // settings

    logic [7:0] onOff_r,  onOff_nxt;
    logic [7:0] olEn_r,   olEn_nxt;
    logic [7:0] ovPol_r,  ovPol_nxt;
    logic [7:0] retry_r,  retry_nxt;
    logic [7:0] thermal_limit_r,   thermal_limit_nxt;
    logic [7:0] timer_r,  timer_nxt;
    logic [7:0] pair_r,   pair_nxt;
    logic [7:0] andOr_r,  andOr_nxt;
    logic [7:0] ovHold_r, ovHold_nxt;
    logic       ovPrev_r, ovPrev_nxt;
    logic [4:0] cmdCode;
    logic [7:0] dataByte;

    assign cmdCode  = word_r[`OSW_CMD_MSB:`OSW_CMD_LSB];
    assign dataByte = word_r[7:0];

    always_comb begin
        onOff_nxt  = onOff_r;
        olEn_nxt   = olEn_r;
        ovPol_nxt  = ovPol_r;
        retry_nxt  = retry_r;
        thermal_limit_nxt   = thermal_limit_r;
        timer_nxt  = timer_r;
        pair_nxt   = pair_r;
        andOr_nxt  = andOr_r;
        ovHold_nxt = ovHold_r;
        ovPrev_nxt = ovSync;
        if (cmdStb_r) begin
            case (cmdCode)
                CMD_ONOFF: begin
                    onOff_nxt  = dataByte;
                    ovHold_nxt = '0;
                end
                CMD_OLEN:  olEn_nxt  = dataByte;
                CMD_OVPOL: ovPol_nxt = dataByte;
                CMD_RETRY: retry_nxt = dataByte;
                CMD_THERMAL_LIMIT:  thermal_limit_nxt  = dataByte;
                CMD_TIMER: timer_nxt = dataByte;
                CMD_PAIR:  pair_nxt  = dataByte;
                CMD_ANDOR: andOr_nxt = dataByte;
                default: ;
            endcase
        end
        // leaving over-voltage: policy 0 holds the output off until a
        // fresh on/off word; the set wins over a same-cycle clear
        if (ovPrev_r && !ovSync)
            ovHold_nxt = ovHold_nxt | ~ovPol_r;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            onOff_r  <= `OSW_RST_ZERO;
            olEn_r   <= `OSW_RST_ZERO;
            pair_r   <= `OSW_RST_ZERO;
            andOr_r  <= `OSW_RST_ZERO;
            ovPol_r  <= `OSW_RST_ONES;
            retry_r  <= `OSW_RST_ONES;
            thermal_limit_r   <= `OSW_RST_ONES;
            timer_r  <= `OSW_RST_ONES;
            ovHold_r <= `OSW_RST_ZERO;
            ovPrev_r <= 1'b0;
        end else begin
            onOff_r  <= onOff_nxt;
            olEn_r   <= olEn_nxt;
            pair_r   <= pair_nxt;
            andOr_r  <= andOr_nxt;
            ovPol_r  <= ovPol_nxt;
            retry_r  <= retry_nxt;
            thermal_limit_r   <= thermal_limit_nxt;
            timer_r  <= timer_nxt;
            ovHold_r <= ovHold_nxt;
            ovPrev_r <= ovPrev_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // serial bits combined with the direct-drive pins

    logic [7:0] want;
    logic [3:0] pinEn;
    logic [3:0] pinComb;

    always_comb begin
        want = '0;
        for (int k = 0; k < 4; k++) begin
            pinEn[k] = ~pair_r[`OSW_PIN_LSB + k];
            if (pair_r[`OSW_PAIR_LSB + k])
                pinComb[k] = onOff_r[2*k] | onOff_r[2*k+1];
            else
                pinComb[k] = onOff_r[2*k];
            if (pinEn[k])
                pinComb[k] = andOr_r[k] ? (pinComb[k] & pinSync[k])
                                        : (pinComb[k] | pinSync[k]);
            want[2*k] = pinComb[k];
            want[2*k+1] = pair_r[`OSW_PAIR_LSB + k] ? pinComb[k]
                                                    : onOff_r[2*k+1];
        end
    end

    logic [7:0] enable;
    // the cycle that leaves over-voltage still blocks, so the hold is in
    // place before any output could come back
    assign enable = want & ~ovHold_r & {8{~(ovSync | ovPrev_r)}};

    ////////////////////////////////////////////////////////////////////
    // per-output short protection; one shared counter times both the
    // on-time fault window and the off-time refresh

    logic [7:0] allow;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    for (genvar i = 0; i < 8; i++) begin : g_prot
        prot_t         st_r, st_nxt;
        logic [CW-1:0] cnt_r, cnt_nxt;
        prot_t         tripTo;
        logic          useTimer;
        logic          hot;

        always_comb begin
            useTimer = ~thermal_limit_r[i] | timer_r[i];
            hot      = thermal_limit_r[i] & thermSync[i];
            if (!retry_r[i])
                tripTo = ST_LATCH;
            else if (useTimer)
                tripTo = ST_OFF;
            else
                tripTo = ST_TWAIT;
            st_nxt  = st_r;
            cnt_nxt = '0;
            unique case (st_r)
                ST_RUN: begin
                    if (!enable[i]) begin
                        cnt_nxt = '0;
                    end else if (hot) begin
                        st_nxt = tripTo;
                    end else if (useTimer && (scSync[i] || svSync[i])) begin
                        if (cnt_r >= (scSync[i] ? CLIMIT_LAST
                                                : SHORT_LAST))
                            st_nxt = tripTo;
                        else
                            cnt_nxt = cnt_r + 1'b1;
                    end
                end
                ST_OFF: begin
                    if (!enable[i])
                        st_nxt = ST_RUN;
                    else if (cnt_r >= REFRESH_LAST && !hot)
                        st_nxt = ST_RUN;
                    else if (cnt_r < REFRESH_LAST)
                        cnt_nxt = cnt_r + 1'b1;
                    else
                        cnt_nxt = cnt_r;
                end
                ST_TWAIT: begin
                    if (!enable[i] || !thermSync[i])
                        st_nxt = ST_RUN;
                end
                ST_LATCH: begin
                    if (!want[i])
                        st_nxt = ST_RUN;
                end
                default: st_nxt = ST_RUN;
            endcase
        end

        always_ff @(posedge core_clk) begin
            if (rst) begin
                st_r  <= ST_RUN;
                cnt_r <= '0;
            end else begin
                st_r  <= st_nxt;
                cnt_r <= cnt_nxt;
            end
        end

        assign allow[i] = (st_r == ST_RUN);

        a_latch_holds: assert property (
            st_r == ST_LATCH && want[i] |=> st_r == ST_LATCH
                                            && !switchOutputs_r[i])
            else $error("latched output left its latch");
        a_thermal_trip: assert property (
            st_r == ST_RUN && enable[i] && hot
            |=> st_r != ST_RUN ##1 !switchOutputs_r[i])
            else $error("thermal trip did not turn output off");
        a_off_dwell: assert property (
            st_r == ST_OFF && enable[i] && cnt_r < REFRESH_LAST
            |=> st_r == ST_OFF)
            else $error("refresh off period ended early");
    end

    ////////////////////////////////////////////////////////////////////
    // off-state open-load: each pair released in its own quarter period

    logic       phaseTick;
    logic [1:0] phase_r, phase_nxt;
    logic [BW-1:0] blank_r [4];
    logic [BW-1:0] blank_nxt [4];
    logic [7:0] olFlag_nxt;

    period_counter #(.PERIOD(REFRESH_CYC / 4)) u_phase (
        .clk  (core_clk),
        .rst  (rst),
        .tick (phaseTick)
    );

    always_comb begin
        phase_nxt  = phaseTick ? phase_r + 2'd1 : phase_r;
        olFlag_nxt = openLoadFlag_r;
        for (int k = 0; k < 4; k++) begin
            blank_nxt[k] = (blank_r[k] != '0) ? blank_r[k] - 1'b1 : '0;
            if (phaseTick && phase_r == 2'(k)) begin
                blank_nxt[k] = REDET_LOAD;
                olFlag_nxt[2*k]   = openLoadFlag_r[2*k]   & ~timer_r[2*k];
                olFlag_nxt[2*k+1] = openLoadFlag_r[2*k+1] & ~timer_r[2*k+1];
            end else if (blank_r[k] == '0) begin
                for (int j = 2*k; j < 2*k+2; j++) begin
                    if (olSync[j] && olEn_r[j] && !switchOutputs_r[j])
                        olFlag_nxt[j] = 1'b1;
                end
            end
        end
        // a flag is only kept while its pull-down is on
        olFlag_nxt = olFlag_nxt & olEn_r;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            phase_r        <= '0;
            openLoadFlag_r <= '0;
            for (int k = 0; k < 4; k++)
                blank_r[k] <= '0;
        end else begin
            phase_r        <= phase_nxt;
            openLoadFlag_r <= olFlag_nxt;
            for (int k = 0; k < 4; k++)
                blank_r[k] <= blank_nxt[k];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registered outputs

    always_ff @(posedge core_clk) begin
        if (rst) begin
            switchOutputs_r  <= '0;
            pulldownEn_r     <= `OSW_RST_ZERO;
            faultStatus_r    <= '0;
            curLimitActive_r <= '0;
        end else begin
            switchOutputs_r  <= enable & allow;
            pulldownEn_r     <= olEn_r;
            faultStatus_r    <= ~allow;
            curLimitActive_r <= `OSW_RST_ONES;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    sequence s_word_taken;
        csRise ##1 cmdStb_r;
    endsequence

    a_word_commit: assert property (
        s_word_taken ##0 cmdCode == CMD_ONOFF
        |=> onOff_r == $past(word_r[7:0]))
        else $error("on/off word not committed after select rise");
    a_no_idle_cmd: assert property (
        !$past(csRise) |-> !cmdStb_r)
        else $error("command strobe without select rise");
    a_pulldown_write: assert property (
        $changed(olEn_r) |-> $past(cmdStb_r && cmdCode == CMD_OLEN))
        else $error("pull-down enable changed without its command");
    a_ov_off: assert property (
        ovSync |=> switchOutputs_r == 8'h00)
        else $error("output on during over-voltage");
    a_ov_hold: assert property (
        ovPrev_r && !ovSync && ovPol_r == 8'h00 && !cmdStb_r
        |=> switchOutputs_r == 8'h00 ##1 switchOutputs_r == 8'h00)
        else $error("output resumed with shutdown policy");
    a_pin_or: assert property (
        pinEn[0] && !pair_r[4] && !andOr_r[0] && pinSync[0]
        |-> want[0])
        else $error("enabled pin not OR-ed into output 1");
    a_pin_off: assert property (
        !pinEn[1] && !pair_r[5] |-> want[2] == onOff_r[2])
        else $error("disabled pin still steers output 3");
    a_pair_both: assert property (
        pair_r[4] && pinEn[0] && !andOr_r[0]
        && (onOff_r[0] || onOff_r[1] || pinSync[0])
        |-> want[1:0] == 2'b11)
        else $error("paired outputs 1-2 not both on");
    a_reset_vals: assert property (
        $fell(rst) |-> onOff_r == 8'h00 && retry_r == 8'hff
                       && thermal_limit_r == 8'hff && pair_r == 8'h00)
        else $error("settings wrong after reset");
endmodule
`default_nettype wire

/* File: hdl/octal_switch_pkg.sv */
// types shared by the octal switch command logic
// assumes osw_consts.svh is on the include path
`default_nettype none
`include "osw_consts.svh"
package octal_switch_pkg;
    typedef enum logic [4:0] {
        CMD_ONOFF = `OSW_CMD_ONOFF,
        CMD_OLEN  = `OSW_CMD_OLEN,
        CMD_OVPOL = `OSW_CMD_OVPOL,
        CMD_RETRY = `OSW_CMD_RETRY,
        CMD_THERMAL_LIMIT  = `OSW_CMD_THERMAL_LIMIT,
        CMD_TIMER = `OSW_CMD_TIMER,
        CMD_PAIR  = `OSW_CMD_PAIR,
        CMD_ANDOR = `OSW_CMD_ANDOR
    } cmd_t;

    typedef enum logic [3:0] {
        ST_RUN   = 4'b0001,
        ST_OFF   = 4'b0010,
        ST_TWAIT = 4'b0100,
        ST_LATCH = 4'b1000
    } prot_t;
endpackage
`default_nettype wire

/* File: hdl/osw_consts.svh */
// octal switch command logic: command codes, reset values, timing figures
// assumes a 40 MHz core clock and a 16-bit serial command word
//
// Contract
// - host shifts 16-bit words MSB first; upper byte command, lower settings
// - on/off byte: bit 7 drives output 8 down to bit 0 output 1
// - pull-down sources off after reset; enabled only by writing ones
// - off-state open-load need not be reported while pull-down is disabled
// - after over-voltage: policy 0 keeps outputs off, 1 restores them
// - voltage short under timer: off about 10 ms, on about 500 us
// - current-limit short under timer: off about 10 ms, on about 50 us
// - retry 1, thermal 0: timer protection only, fault-timer bit ignored
// - retry 1, thermal 1, timer 0: re-enable only after thermal recovery
// - all three bits one: retry when period elapsed and temperature low
// - retry 0: latch shorted output off after first trip, no retry
// - open-load released and re-detected each retry period, pairs phased; flags are only released where the fault-timer bit is 1
// - current-limit loop of every output always active in normal mode
// - pair bits: 0 individual, 1 joint; bit 4 pairs outputs 1 and 2
// - paired 1-2 with pin enabled and combine bit 0: either serial bit or pin turns both on
// - pin-enable bits 0..3 for pins of outputs 1,3,5,7; 0 enables
// - enabled pin: OR with serial bit when combine bit 0, AND when 1
// - disabled pin: pin and combine bit ignored, serial bit alone
// - command from word bits 15..11, acted on at chip-select rising edge
// - command codes 00001 to 01000 as listed for the eight commands
// - reset: on/off, open-load, pairing, combine zero; others all ones
`ifndef OSW_CONSTS_SVH
`define OSW_CONSTS_SVH

`define OSW_WORD_BITS   16
`define OSW_CMD_MSB     15
`define OSW_CMD_LSB     11
`define OSW_PAIR_LSB    4
`define OSW_PIN_LSB     0

`define OSW_CMD_ONOFF   5'h01
`define OSW_CMD_OLEN    5'h02
`define OSW_CMD_OVPOL   5'h03
`define OSW_CMD_RETRY   5'h04
`define OSW_CMD_THERMAL_LIMIT    5'h05
`define OSW_CMD_TIMER   5'h06
`define OSW_CMD_PAIR    5'h07
`define OSW_CMD_ANDOR   5'h08

`define OSW_RST_ZERO    8'h00
`define OSW_RST_ONES    8'hff

`define OSW_CLK_MHZ     40
`define OSW_REFRESH_MS  10
`define OSW_SHORT_US    500
`define OSW_CLIMIT_US   50
`define OSW_REDETECT_US 500

`endif

/* File: hdl/period_counter.sv */
// free-running counter giving a one-cycle tick every PERIOD cycles
// assumes PERIOD of at least 2
`default_nettype none
module period_counter #(
    parameter int PERIOD = 100000
) (
    input  wire logic clk,
    input  wire logic rst,
    output var  logic tick
);
    localparam int CW = $clog2(PERIOD);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          tick_nxt;

    always_comb begin
        tick_nxt = (cnt_r == LAST);
        cnt_nxt  = tick_nxt ? '0 : cnt_r + 1'b1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick  <= tick_nxt;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/sync_two_flop.sv */
// two-flop synchroniser for a bus of independent levels
// assumes each bit is a slow level; no word coherence is promised
`default_nettype none
module sync_two_flop #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* File: test/octal_switch_command_logic_test.sv */
// self-checking bench for the octal switch command logic
// assumes short sim periods: refresh 400, short 40, re-detect 20 cycles
`default_nettype none
module octal_switch_command_logic_test;
    timeunit 1ns;
    timeprecision 1ps;
    import octal_switch_pkg::*;

    logic       core_clk;
    logic       rst;
    logic [3:0] directPin;
    logic       supplyOverVolt;
    logic [7:0] thermalLimit;
    logic [7:0] shortVolt;
    logic [7:0] shortCur;
    logic [7:0] openLoadRaw;
    logic [7:0] outs;
    logic [7:0] pullEn;
    logic [7:0] fault;
    logic [7:0] curLim;
    logic [7:0] olFlag;
    logic       linkClk;
    logic       linkCsN;
    logic       linkMosi;
    int         numErrors = 0;
    int         totalChecks = 0;

    spi_host_model u_host (
        .linkClk (linkClk),
        .linkCsN (linkCsN),
        .linkMosi(linkMosi)
    );

    octal_switch_core #(
        .REFRESH_CYC (400),
        .SHORT_CYC   (40),
        .REDETECT_CYC(20)
    ) u_dut (
        .core_clk        (core_clk),
        .rst             (rst),
        .linkClk         (linkClk),
        .linkCsN         (linkCsN),
        .linkMosi        (linkMosi),
        .directPin       (directPin),
        .supplyOverVolt  (supplyOverVolt),
        .thermalLimit    (thermalLimit),
        .shortVolt       (shortVolt),
        .shortCur        (shortCur),
        .openLoadRaw     (openLoadRaw),
        .switchOutputs_r (outs),
        .pulldownEn_r    (pullEn),
        .faultStatus_r   (fault),
        .openLoadFlag_r  (olFlag),
        .curLimitActive_r(curLim)
    );

    always #12.5 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        totalChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // settings take at most 5 core edges after select rises
    task automatic cmd(input cmd_t c, input logic [7:0] d);
        u_host.send({c, 3'h0, d});
        cyc(8);
    endtask

    task automatic final_report();
        $display("errors %0d checks %0d", numErrors, totalChecks);
        if (numErrors == 0 && totalChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        directPin = 4'h0;
        supplyOverVolt = 1'b0;
        thermalLimit = 8'h00;
        shortVolt = 8'h00;
        shortCur = 8'h00;
        openLoadRaw = 8'h00;
        cyc(2);
        rst <= 1'b0;
        cyc(4);
        check("outputs", 8'h00, outs);
        check("pulldown", 8'h00, pullEn);
        check("curlimit", 8'hff, curLim);
        cmd(CMD_ONOFF, 8'ha5);
        check("onoff", 8'ha5, outs);
        u_host.send(16'hf8ff);
        cyc(8);
        check("bad code", 8'ha5, outs);
        u_host.send(16'h0f3c);
        cyc(8);
        check("ignored bits", 8'h3c, outs);
        cmd(CMD_OLEN, 8'h3c);
        check("pulldown", 8'h3c, pullEn);
        cmd(CMD_ONOFF, 8'h00);
        directPin <= 4'h1;
        cyc(5);
        check("pin or", 8'h01, outs);
        cmd(CMD_PAIR, 8'h10);
        check("paired", 8'h03, outs);
        cmd(CMD_PAIR, 8'h11);
        check("pin off", 8'h00, outs);
        cmd(CMD_PAIR, 8'h00);
        cmd(CMD_ANDOR, 8'h01);
        check("and 0", 8'h00, outs);
        cmd(CMD_ONOFF, 8'h01);
        check("and 1", 8'h01, outs);
        directPin <= 4'h0;
        cyc(5);
        check("and pin", 8'h00, outs);
        cmd(CMD_ANDOR, 8'h00);
        directPin <= 4'h2;
        cmd(CMD_PAIR, 8'h02);
        check("pin3 off", 8'h01, outs);
        cmd(CMD_PAIR, 8'h00);
        check("pin3 or", 8'h05, outs);
        directPin <= 4'h0;
        cmd(CMD_ONOFF, 8'h81);
        cmd(CMD_OVPOL, 8'h00);
        supplyOverVolt <= 1'b1;
        cyc(5);
        check("ov off", 8'h00, outs);
        supplyOverVolt <= 1'b0;
        cyc(5);
        check("ov stay", 8'h00, outs);
        cmd(CMD_OVPOL, 8'hff);
        cmd(CMD_ONOFF, 8'h81);
        supplyOverVolt <= 1'b1;
        cyc(5);
        supplyOverVolt <= 1'b0;
        cyc(5);
        check("ov resume", 8'h81, outs);
        cmd(CMD_THERMAL_LIMIT, 8'h00);
        shortVolt <= 8'h01;
        cyc(60);
        check("vshort fault", 8'h01, fault);
        check("vshort off", 8'h80, outs);
        shortVolt <= 8'h00;
        cyc(420);
        check("retried", 8'h81, outs);
        shortCur <= 8'h01;
        cyc(1900);
        check("climit wait", 8'h00, fault);
        cyc(200);
        check("climit trip", 8'h01, fault);
        shortCur <= 8'h00;
        cyc(420);
        check("climit retry", 8'h81, outs);
        cmd(CMD_RETRY, 8'h00);
        shortVolt <= 8'h01;
        cyc(60);
        shortVolt <= 8'h00;
        cyc(420);
        check("latched", 8'h80, outs);
        cmd(CMD_TIMER, 8'h00);
        openLoadRaw <= 8'h04;
        cyc(30);
        check("open load", 8'h04, olFlag);
        cmd(CMD_RETRY, 8'hff);
        cmd(CMD_THERMAL_LIMIT, 8'hff);
        thermalLimit <= 8'h80;
        cyc(5);
        check("hot off", 8'h00, outs);
        check("hot fault", 8'h81, fault);
        thermalLimit <= 8'h00;
        cyc(5);
        check("cool on", 8'h80, outs);
        cmd(CMD_OLEN, 8'h00);
        check("ol cleared", 8'h00, olFlag);
        check("pulldown off", 8'h00, pullEn);
        final_report();
    end

    // whole sequence needs about 110 us
    initial begin
        #1000000;
        numErrors++;
        final_report();
    end
endmodule
`default_nettype wire

/* File: test/spi_host_model.sv */
// host side of the serial link: shifts 16-bit command words, MSB first
// assumes the device samples data on the rising edge of the link clock
`default_nettype none
module spi_host_model (
    output var logic linkClk,
    output var logic linkCsN,
    output var logic linkMosi
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        linkClk = 1'b0;
        linkCsN = 1'b1;
        linkMosi = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // clock stands still between frames; once released the data line shows
    // the inverse of its last bit, so a stale value is never mistaken
    task automatic send(input logic [15:0] word);
        linkCsN = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            linkMosi = word[i];
            #16 linkClk = 1'b1;
            #16 linkClk = 1'b0;
        end
        #16 linkCsN = 1'b1;
        linkMosi = ~linkMosi;
        #200;
    endtask
endmodule
`default_nettype wire
